// ---- logic/cic_pkg.sv ----
// constants, types and register map of the clock, interval and cross-cpu control block
// assumes one cpu clock at 200 MHz; the register bus is classic wishbone, 32-bit
package cic_pkg;

  // ----------------------------------------------------------------
  // instruction group
  // ----------------------------------------------------------------
  localparam int          INSTR_W      = 16;
  localparam logic [9:0]  OPC_GROUP    = 10'h00c;   // octal 0014 in bits 15..6
  localparam int          J_LSB        = 3;
  localparam int          K_LSB        = 0;
  localparam logic [2:0]  K_CLK_WRITE  = 3'h0;
  localparam logic [2:0]  K_SEND_IRQ   = 3'h1;
  localparam logic [2:0]  K_CLEAR_IRQ  = 3'h2;
  localparam logic [2:0]  K_CLUSTER    = 3'h3;
  localparam logic [2:0]  K_INTERVAL   = 3'h4;
  localparam logic [2:0]  K_CLK_CLEAR  = 3'h5;
  localparam logic [2:0]  K_CLK_ENABLE = 3'h6;
  localparam logic [2:0]  K_CLK_DIS    = 3'h7;
  localparam logic [2:0]  J_ZERO       = 3'h0;

  typedef enum logic [3:0] {
    OP_NONE       = 4'b0000,
    OP_CLK_WRITE  = 4'b0001,
    OP_SEND_IRQ   = 4'b0010,
    OP_CLEAR_IRQ  = 4'b0011,
    OP_CLUSTER    = 4'b0100,
    OP_INTERVAL   = 4'b0101,
    OP_CLK_CLEAR  = 4'b0110,
    OP_CLK_ENABLE = 4'b0111,
    OP_CLK_DIS    = 4'b1000
  } cic_op_e;

  typedef struct packed {
    logic               valid;
    logic [INSTR_W-1:0] code;
  } cic_instr_s;

  // ----------------------------------------------------------------
  // shared register banks
  // ----------------------------------------------------------------
  localparam int          SEM_W      = 32;
  localparam int          SA_W       = 24;
  localparam int          SS_W       = 64;
  localparam int          BANK_DEPTH = 8;
  localparam int          IDX_W      = 5;
  localparam logic [1:0]  BANK_SEM   = 2'h0;
  localparam logic [1:0]  BANK_ADDR  = 2'h1;
  localparam logic [1:0]  BANK_SCAL  = 2'h2;
  localparam logic [2:0]  CLUSTER_NONE = 3'h0;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [1:0]       bank;
    logic [IDX_W-1:0] index;
    logic [SS_W-1:0]  wdata;
  } cic_shr_req_s;

  // ----------------------------------------------------------------
  // wishbone register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0]  REG_STATUS    = 6'h00;
  localparam logic [5:0]  REG_MASK      = 6'h04;
  localparam logic [5:0]  REG_CLOCK_LO  = 6'h08;
  localparam logic [5:0]  REG_CLOCK_HI  = 6'h0c;
  localparam logic [5:0]  REG_COUNTDOWN = 6'h10;
  localparam logic [5:0]  REG_RELOAD    = 6'h14;
  localparam logic [5:0]  REG_STATE     = 6'h18;
  localparam int          EV_W          = 2;
  localparam int          EV_EXPIRE     = 0;
  localparam int          EV_CROSS      = 1;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
  localparam int          STATE_EN_BIT    = 4;
  localparam int          STATE_REQ_BIT   = 5;
  localparam int          STATE_CROSS_BIT = 6;
  localparam int          STATE_ARMED_BIT = 7;

endpackage

// ---- logic/cic_ctrl.sv ----
// clock, interval countdown, cross-cpu request and cluster select logic of one cpu
// assumes the cpu presents one issued instruction per valid cycle together with
// the value of the scalar register that its j field names; wishbone master is classic
//
// How it works
// - every operation of the group acts only in monitor mode, else passes
// - clock write copies the selected scalar source into the wall clock
// - clock write with j zero clears the wall clock
// - send operation raises a one-cycle request toward another cpu
// - a cross-cpu request stays pending until this cpu clears it
// - clear operation removes the pending request from another cpu
// - cluster select loads j; zero is none, one to five select clusters
// - with no cluster, shared writes do nothing and reads return zero
// - each cluster owns its own semaphore, address and scalar banks
// - interval load writes low 32 source bits to reload and countdown
// - the 32-bit countdown drops by one each clock until zero
// - at zero it sets the clock request, reloads and repeats
// - the clock request stays set until a clock clear operation
// - the clock clear operation drops a pending clock request
// - the enable operation lets clock interrupts through
// - the disable operation blocks clock interrupts until the next enable
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

module cic_ctrl
  import cic_pkg::*;
#(
  parameter int RTC_W        = 64,
  parameter int CNT_W        = 32,
  parameter int NUM_CLUSTERS = 5
) (
  input  wire  logic               clk,
  input  wire  logic               nrst,
  input  wire  cic_instr_s         instr,
  input  wire  logic [SS_W-1:0]    scalar_source,
  input  wire  logic               monitor_mode,
  input  wire  logic               cross_irq_req_in,
  input  wire  cic_shr_req_s       shr_req,
  output logic [SS_W-1:0]          shr_rdata,
  output logic                     shr_rvalid,
  output logic [RTC_W-1:0]         wall_clock,
  output logic                     clock_irq,
  output logic                     send_cpu_irq,
  output logic                     cross_cpu_irq_flag,
  output logic [2:0]               cluster_num,
  input  wire  logic               wb_cyc_i,
  input  wire  logic               wb_stb_i,
  input  wire  logic               wb_we_i,
  input  wire  logic [5:0]         wb_adr_i,
  input  wire  logic [3:0]         wb_sel_i,
  input  wire  logic [31:0]        wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RTC_W < 33 || RTC_W > 64) begin : g_bad_rtc
    $error("RTC_W must lie in 33..64");
  end
  if (CNT_W != 32) begin : g_bad_cnt
    $error("CNT_W must be 32");
  end
  if (NUM_CLUSTERS < 1 || NUM_CLUSTERS > 7) begin : g_bad_cl
    $error("NUM_CLUSTERS must lie in 1..7");
  end

  localparam logic [2:0] MAX_CL = 3'(NUM_CLUSTERS);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic cic_op_e decode_op(input logic [INSTR_W-1:0] code);
    cic_op_e op;
    op = OP_NONE;
    if (code[INSTR_W-1:6] == OPC_GROUP) begin
      case (code[K_LSB+:3])
        K_CLK_WRITE:  op = OP_CLK_WRITE;
        K_SEND_IRQ:   op = (code[J_LSB+:3] == J_ZERO) ? OP_SEND_IRQ : OP_NONE;
        K_CLEAR_IRQ:  op = (code[J_LSB+:3] == J_ZERO) ? OP_CLEAR_IRQ : OP_NONE;
        K_CLUSTER:    op = OP_CLUSTER;
        K_INTERVAL:   op = OP_INTERVAL;
        K_CLK_CLEAR:  op = OP_CLK_CLEAR;
        K_CLK_ENABLE: op = OP_CLK_ENABLE;
        K_CLK_DIS:    op = OP_CLK_DIS;
        default:      op = OP_NONE;
      endcase
    end
    return op;
  endfunction

  // register zero as source reads as zero
  function automatic logic [SS_W-1:0] pick_src(input logic [2:0] j,
                                               input logic [SS_W-1:0] s);
    return (j == J_ZERO) ? '0 : s;
  endfunction

  cic_op_e          op_now;
  logic [2:0]       j_fld;
  logic [SS_W-1:0]  src_sel;

  always_comb begin
    j_fld   = instr.code[J_LSB+:3];
    src_sel = pick_src(j_fld, scalar_source);
    op_now  = OP_NONE;
    if (instr.valid && monitor_mode) begin
      op_now = decode_op(instr.code);
    end
  end

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] interval_reload_value;
  logic [CNT_W-1:0] interval_countdown;
  logic             armed;
  logic             clk_req;
  logic             clk_en;
  logic             cross_pending;
  logic             expire;
  logic [CNT_W-1:0] next_reload;
  logic [CNT_W-1:0] next_countdown;
  logic             next_armed;
  logic             next_clk_req;
  logic             next_clk_en;
  logic             next_cross;
  logic [RTC_W-1:0] next_wall_clock;
  logic [2:0]       next_cluster;

  always_comb begin
    next_wall_clock = wall_clock + RTC_W'(1);
    if (op_now == OP_CLK_WRITE) begin
      next_wall_clock = RTC_W'(src_sel);
    end

    next_reload    = interval_reload_value;
    next_countdown = interval_countdown;
    next_armed     = armed;
    expire         = 1'b0;
    // countdown keeps running whatever the enable says
    if (op_now == OP_INTERVAL) begin
      next_reload    = src_sel[CNT_W-1:0];
      next_countdown = src_sel[CNT_W-1:0];
      next_armed     = 1'b1;
    end else if (armed && interval_countdown == '0) begin
      expire         = 1'b1;
      next_countdown = interval_reload_value;
    end else if (armed) begin
      next_countdown = interval_countdown - CNT_W'(1);
    end

    // a set in the same cycle as the clear wins
    next_clk_req = clk_req;
    if (op_now == OP_CLK_CLEAR) begin
      next_clk_req = 1'b0;
    end
    if (expire) begin
      next_clk_req = 1'b1;
    end

    next_clk_en = clk_en;
    if (op_now == OP_CLK_ENABLE) begin
      next_clk_en = 1'b1;
    end else if (op_now == OP_CLK_DIS) begin
      next_clk_en = 1'b0;
    end

    next_cross = cross_pending;
    if (op_now == OP_CLEAR_IRQ) begin
      next_cross = 1'b0;
    end
    if (cross_irq_req_in) begin
      next_cross = 1'b1;
    end

    next_cluster = cluster_num;
    if (op_now == OP_CLUSTER && j_fld <= MAX_CL) begin
      next_cluster = j_fld;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wall_clock            <= '0;
      interval_reload_value <= '0;
      interval_countdown    <= '0;
      armed                 <= 1'b0;
      clk_req               <= 1'b0;
      clk_en                <= 1'b0;
      cross_pending         <= 1'b0;
      cluster_num           <= CLUSTER_NONE;
      clock_irq             <= 1'b0;
      send_cpu_irq          <= 1'b0;
      cross_cpu_irq_flag    <= 1'b0;
    end else begin
      wall_clock            <= next_wall_clock;
      interval_reload_value <= next_reload;
      interval_countdown    <= next_countdown;
      armed                 <= next_armed;
      clk_req               <= next_clk_req;
      clk_en                <= next_clk_en;
      cross_pending         <= next_cross;
      cluster_num           <= next_cluster;
      clock_irq             <= clk_req && clk_en;
      send_cpu_irq          <= (op_now == OP_SEND_IRQ);
      cross_cpu_irq_flag    <= cross_pending && !monitor_mode;
    end
  end

  // ----------------------------------------------------------------
  // shared banks, one set per cluster
  // ----------------------------------------------------------------
  localparam int BANK_WORDS = NUM_CLUSTERS * BANK_DEPTH;

  logic [SEM_W-1:0] sem_mem [NUM_CLUSTERS];
  logic [SA_W-1:0]  sa_mem  [BANK_WORDS];
  logic [SS_W-1:0]  ss_mem  [BANK_WORDS];
  logic [5:0]       cl_idx;
  logic [5:0]       word_idx;
  logic             shr_live;
  logic [SS_W-1:0]  next_rdata;
  logic             next_rvalid;

  always_comb begin
    cl_idx      = 6'(cluster_num) - 6'h1;
    word_idx    = 6'(cl_idx * 6'(BANK_DEPTH)) + 6'(shr_req.index[2:0]);
    shr_live    = shr_req.valid && cluster_num != CLUSTER_NONE;
    next_rvalid = shr_req.valid && !shr_req.write;
    next_rdata  = '0;
    if (shr_live && !shr_req.write) begin
      case (shr_req.bank)
        BANK_SEM:  next_rdata = SS_W'(sem_mem[cl_idx[2:0]]);
        BANK_ADDR: next_rdata = SS_W'(sa_mem[word_idx]);
        BANK_SCAL: next_rdata = ss_mem[word_idx];
        default:   next_rdata = '0;
      endcase
    end
  end

  // storage has no reset; software initialises it before use
  always_ff @(posedge clk) begin
    if (shr_live && shr_req.write) begin
      case (shr_req.bank)
        BANK_SEM:  sem_mem[cl_idx[2:0]][shr_req.index] <= shr_req.wdata[0];
        BANK_ADDR: sa_mem[word_idx] <= shr_req.wdata[SA_W-1:0];
        BANK_SCAL: ss_mem[word_idx] <= shr_req.wdata;
        default:   ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shr_rdata  <= '0;
      shr_rvalid <= 1'b0;
    end else begin
      shr_rdata  <= next_rdata;
      shr_rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave and interrupt status
  // ----------------------------------------------------------------
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] next_mask;
  logic [EV_W-1:0] events;
  logic            wb_hit;
  logic [31:0]     next_dat;
  logic [63:0]     clock_ext;

  always_comb begin
    wb_hit    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    clock_ext = 64'(wall_clock);
    events    = '0;
    events[EV_EXPIRE] = expire;
    events[EV_CROSS]  = cross_irq_req_in;
    next_dat  = '0;
    if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS:    next_dat = 32'(status);
        REG_MASK:      next_dat = 32'(mask);
        REG_CLOCK_LO:  next_dat = clock_ext[31:0];
        REG_CLOCK_HI:  next_dat = clock_ext[63:32];
        REG_COUNTDOWN: next_dat = interval_countdown;
        REG_RELOAD:    next_dat = interval_reload_value;
        REG_STATE: begin
          next_dat[2:0]          = cluster_num;
          next_dat[STATE_EN_BIT]    = clk_en;
          next_dat[STATE_REQ_BIT]   = clk_req;
          next_dat[STATE_CROSS_BIT] = cross_pending;
          next_dat[STATE_ARMED_BIT] = armed;
        end
        default:       next_dat = '0;
      endcase
    end
    // read clears, but an event in the same cycle survives
    next_status = status;
    if (wb_hit && !wb_we_i && wb_adr_i == REG_STATUS) begin
      next_status = '0;
    end
    next_status = next_status | events;
    next_mask = mask;
    if (wb_hit && wb_we_i && wb_adr_i == REG_MASK && wb_sel_i[0]) begin
      next_mask = wb_dat_i[EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status   <= '0;
      mask     <= MASK_RESET;
      wb_dat_o <= '0;
      wb_ack_o <= 1'b0;
      irq      <= 1'b0;
    end else begin
      status   <= next_status;
      mask     <= next_mask;
      wb_dat_o <= next_dat;
      wb_ack_o <= wb_hit;
      irq      <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_priv_gate: assert property (instr.valid && !monitor_mode && !armed |=>
    !armed && $stable(interval_reload_value))
    else $error("interval loaded outside monitor mode");
  a_clock_write: assert property (op_now == OP_CLK_WRITE |=>
    wall_clock == $past(src_sel[RTC_W-1:0]))
    else $error("wall clock not loaded from source");
  a_clock_zero: assert property (op_now == OP_CLK_WRITE && j_fld == J_ZERO |=>
    wall_clock == '0)
    else $error("wall clock not cleared by register zero");
  a_send_pulse: assert property (op_now == OP_SEND_IRQ |=> send_cpu_irq ##1
    (send_cpu_irq == ($past(op_now) == OP_SEND_IRQ)))
    else $error("send request not a one-cycle pulse");
  a_cross_flag: assert property (cross_pending && !monitor_mode |=> cross_cpu_irq_flag)
    else $error("cross-cpu flag missing");
  a_cross_hold: assert property (cross_pending && op_now != OP_CLEAR_IRQ |=> cross_pending)
    else $error("cross-cpu request lost");
  a_cross_clear: assert property (op_now == OP_CLEAR_IRQ && !cross_irq_req_in |=>
    !cross_pending)
    else $error("cross-cpu request not cleared");
  a_cluster_load: assert property (op_now == OP_CLUSTER && j_fld <= MAX_CL |=>
    cluster_num == $past(j_fld))
    else $error("cluster number not loaded");
  a_cluster_none: assert property (shr_req.valid && !shr_req.write &&
    cluster_num == CLUSTER_NONE |=> shr_rvalid && shr_rdata == '0)
    else $error("read with no cluster not zero");
  a_cluster_own: assert property (shr_live && shr_req.write && shr_req.bank == BANK_SCAL ##1
    (shr_req.valid && !shr_req.write && shr_req.bank == BANK_SCAL &&
     cluster_num == $past(cluster_num) && shr_req.index == $past(shr_req.index))
    |=> shr_rdata == $past(shr_req.wdata, 2))
    else $error("shared scalar read back wrong");
  a_interval_load: assert property (op_now == OP_INTERVAL |=>
    interval_reload_value == interval_countdown &&
    interval_countdown == $past(src_sel[CNT_W-1:0]))
    else $error("interval load wrong");
  a_count_step: assert property (armed && interval_countdown != '0 &&
    op_now != OP_INTERVAL |=> interval_countdown == $past(interval_countdown) - CNT_W'(1))
    else $error("countdown did not step");
  a_count_wrap: assert property (armed && interval_countdown == '0 &&
    op_now != OP_INTERVAL |=> clk_req && interval_countdown == $past(interval_reload_value))
    else $error("countdown did not reload");
  a_req_sticky: assert property (clk_req && op_now != OP_CLK_CLEAR |=> clk_req)
    else $error("clock request dropped");
  a_req_clear: assert property (op_now == OP_CLK_CLEAR && !expire |=> !clk_req)
    else $error("clock request not cleared");
  a_clk_enable: assert property (op_now == OP_CLK_ENABLE ##1 clk_req |=> clock_irq)
    else $error("enabled request not presented");
  a_clk_block: assert property (op_now == OP_CLK_DIS |=>
    !clk_en ##1 (!clock_irq || $past(op_now) == OP_CLK_ENABLE))
    else $error("disabled request presented");
  a_irq_gate: assert property (clock_irq |-> $past(clk_req) && $past(clk_en))
    else $error("clock interrupt without request and enable");

endmodule

`default_nettype wire

// ---- bench/cic_peer_cpu.sv ----
// model of another cpu on the cross-cpu request link
// assumes the bench clock and reset; the bench commands its send and clear
`timescale 1ns/100ps
`default_nettype none

module cic_peer_cpu (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic req_in,
  input  wire logic clr,
  input  wire logic fire,
  output logic      pending,
  output logic      req_out
);
  // ----------------------------------------------------------------
  // receiving side
  // ----------------------------------------------------------------
  // only this cpu drops a request; the sender cannot withdraw it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      pending <= 1'b0;
    else if (req_in)
      pending <= 1'b1;
    else if (clr)
      pending <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sending side
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      req_out <= 1'b0;
    else
      req_out <= fire;
  end
endmodule

`default_nettype wire

// ---- bench/cic_ctrl_tb.sv ----
// self-checking bench of the clock, interval and cross-cpu control block
// assumes cic_ctrl with default parameters and the peer cpu model
`timescale 1ns/100ps
`default_nettype none

module cic_ctrl_tb;
  import cic_pkg::*;

  typedef struct packed {
    logic        mm;
    logic [2:0]  j;
    logic [2:0]  k;
    logic [63:0] src;
    logic        chk;
    logic [63:0] clk_v;
    logic [2:0]  cl;
  } cic_row_s;

  logic clk = 0, nrst = 0, monitor_mode = 0, peer_clr = 0, peer_fire = 0;
  logic cross_in, peer_pending, shr_rvalid, clock_irq, send_irq, cross_flag;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r32;
  logic [63:0] scalar_source = 64'h0, shr_rdata, wall_clock, r64;
  logic [2:0]  cluster_num;
  cic_instr_s   instr = '0;
  cic_shr_req_s shr_req = '0;
  int fail_count = 0, total_checks = 0, n;
  cic_row_s rows [8] = '{
    '{1, 2, 0, 64'h0123456789abcdef, 1, 64'h0123456789abcdef, 0},
    '{1, 0, 0, 64'hffffffffffffffff, 1, 64'h0, 0},
    '{1, 1, 3, 64'h0, 0, 64'h0, 1},
    '{1, 5, 3, 64'h0, 0, 64'h0, 5},
    '{0, 3, 3, 64'h0, 0, 64'h0, 5},
    '{1, 6, 3, 64'h0, 0, 64'h0, 5},
    '{1, 2, 3, 64'h0, 0, 64'h0, 2},
    '{1, 0, 3, 64'h0, 0, 64'h0, 0}};

  always #2.5 clk = ~clk;

  cic_ctrl dut (.clk(clk), .nrst(nrst), .instr(instr), .scalar_source(scalar_source),
    .monitor_mode(monitor_mode), .cross_irq_req_in(cross_in), .shr_req(shr_req),
    .shr_rdata(shr_rdata), .shr_rvalid(shr_rvalid), .wall_clock(wall_clock),
    .clock_irq(clock_irq), .send_cpu_irq(send_irq), .cross_cpu_irq_flag(cross_flag),
    .cluster_num(cluster_num), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

  cic_peer_cpu peer (.clk(clk), .nrst(nrst), .req_in(send_irq), .clr(peer_clr),
    .fire(peer_fire), .pending(peer_pending), .req_out(cross_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic op(input logic m, input logic [2:0] j, input logic [2:0] k,
                    input logic [63:0] s);
    @(posedge clk);
    monitor_mode <= m;
    instr <= '{valid: 1'b1, code: {OPC_GROUP, j, k}};
    scalar_source <= s;
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
  endtask

  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // no cycle count assumed; a missing answer is left to the watchdog
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // index 1 everywhere; reads hand back x when no read answer came
  task automatic shr(input logic w, input logic [63:0] d, output logic [63:0] r);
    @(posedge clk);
    shr_req <= '{valid: 1'b1, write: w, bank: BANK_SCAL, index: 5'h01, wdata: d};
    @(posedge clk);
    shr_req.valid <= 1'b0;
    @(posedge clk);
    r = (shr_rvalid === 1'b1) ? shr_rdata : 64'hx;
  endtask

  task automatic edges(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    edges(3);
    nrst = 1'b1;
    chk("cluster_num", cluster_num, 64'h0);
    wb(1'b0, REG_MASK, 32'h0, r32);
    chk("mask", r32, 64'h0);
    $display("test reset done");

    foreach (rows[i]) begin
      op(rows[i].mm, rows[i].j, rows[i].k, rows[i].src);
      if (rows[i].chk) chk("wall_clock", wall_clock, rows[i].clk_v);
      chk("cluster_num", cluster_num, rows[i].cl);
    end
    $display("test rows done");

    // reload of 3: request four edges after load, interrupt one later
    op(1, 0, 6, 0);
    op(1, 3, 4, 64'hffffffff00000003);
    n = 0;
    do begin
      edges(1);
      n++;
    end while (clock_irq !== 1'b1 && n < 20);
    chk("expiry edges", n, 64'd5);
    wb(1'b0, REG_RELOAD, 32'h0, r32);
    chk("reload", r32, 64'h3);
    op(1, 0, 7, 0);
    edges(1);
    chk("clock_irq off", clock_irq, 64'h0);
    wb(1'b0, REG_STATE, 32'h0, r32);
    chk("req and enable", r32[5:4], 64'h2);
    op(1, 0, 6, 0);
    edges(1);
    chk("clock_irq on", clock_irq, 64'h1);
    op(1, 2, 4, 64'd200);
    op(1, 0, 5, 0);
    edges(1);
    chk("clock_irq cleared", clock_irq, 64'h0);
    edges(150);
    chk("clock_irq quiet", clock_irq, 64'h0);
    n = 0;
    do begin
      edges(1);
      n++;
    end while (clock_irq !== 1'b1 && n < 100);
    chk("second expiry", n, 64'd49);
    wb(1'b1, REG_MASK, 32'h1, r32);
    edges(1);
    chk("irq raised", irq, 64'h1);
    wb(1'b0, REG_STATUS, 32'h0, r32);
    chk("status", r32[0], 64'h1);
    wb(1'b0, REG_STATUS, 32'h0, r32);
    chk("status cleared", r32[0], 64'h0);
    edges(1);
    chk("irq", irq, 64'h0);
    $display("test interval done");

    op(1, 0, 1, 0);
    edges(1);
    chk("peer pending", peer_pending, 64'h1);
    @(posedge clk) peer_clr <= 1'b1;
    @(posedge clk) peer_clr <= 1'b0;
    op(0, 0, 1, 0);
    edges(2);
    chk("peer pending", peer_pending, 64'h0);
    @(posedge clk) peer_fire <= 1'b1;
    @(posedge clk) peer_fire <= 1'b0;
    edges(3);
    chk("cross flag", cross_flag, 64'h1);
    edges(20);
    chk("cross flag held", cross_flag, 64'h1);
    wb(1'b0, REG_STATUS, 32'h0, r32);
    chk("cross status", r32[1], 64'h1);
    op(1, 0, 2, 0);
    @(posedge clk) monitor_mode <= 1'b0;
    edges(3);
    chk("cross flag cleared", cross_flag, 64'h0);
    $display("test cross done");

    op(1, 1, 3, 0);
    shr(1'b1, 64'haaaa0000aaaa0001, r64);
    op(1, 2, 3, 0);
    shr(1'b1, 64'h5555000055550002, r64);
    shr(1'b0, 64'h0, r64);
    chk("cluster 2 data", r64, 64'h5555000055550002);
    // back-to-back write and read of one word
    @(posedge clk) shr_req <= '{valid: 1'b1, write: 1'b1, bank: BANK_SCAL, index: 5'h01,
                                wdata: 64'h3333000033330003};
    @(posedge clk) shr_req.write <= 1'b0;
    @(posedge clk) shr_req.valid <= 1'b0;
    @(posedge clk) chk("read after write", shr_rdata, 64'h3333000033330003);
    op(1, 1, 3, 0);
    shr(1'b0, 64'h0, r64);
    chk("cluster 1 data", r64, 64'haaaa0000aaaa0001);
    op(1, 0, 3, 0);
    shr(1'b1, 64'h1234, r64);
    shr(1'b0, 64'h0, r64);
    chk("no cluster read", r64, 64'h0);
    op(1, 1, 3, 0);
    shr(1'b0, 64'h0, r64);
    chk("write ignored", r64, 64'haaaa0000aaaa0001);
    $display("test shared done");
    complete_run();
  end
endmodule

`default_nettype wire
